// file: hdl/rdm_map.vh
// Constants for the reset and debug-mode selector.
`ifndef RDM_MAP_VH
`define RDM_MAP_VH
`define RDM_STABLE_NS 1000
`define RDM_CLK_NS 5
`define RDM_NUM_MODULES 8
`define RDM_SRC_POR 0
`define RDM_SRC_EXT 1
`define RDM_SRC_MOD 2
`define RDM_CLK_SEL_LPOSC 1'h0
`define RDM_CLK_SEL_XTAL 1'h1
`endif

// file: hdl/rdm_reset_debug_mode_select.v
// Reset entry, oscillator-stable hold, debug-mode select and reset generator.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_map.vh"
module rdm_reset_debug_mode_select #(
  parameter NUM_MODULES = `RDM_NUM_MODULES,
  parameter STABLE_NS = `RDM_STABLE_NS
) (
  input wire MCLK,
  input wire RST,
  input wire EXT_RESET_N_IN,
  input wire EXT_RESET_N_DRIVEN,
  input wire POWER_UP_RESET,
  input wire OSC_STABLE,
  input wire TEST_PORT_SELECT_IN,
  input wire TEST_PORT_SELECT_DRIVEN,
  input wire TEST_RESET_N_IN,
  input wire TEST_RESET_N_DRIVEN,
  input wire TEST_MODE_SELECT_IN,
  input wire TEST_MODE_SELECT_DRIVEN,
  input wire TEST_DATA_IN,
  input wire TEST_DATA_DRIVEN,
  input wire [NUM_MODULES-1:0] MODULE_RESET_REQ,
  input wire CAUSE_CLEAR,
  output reg INTERNAL_RESET,
  output reg SYSTEM_BASE_CLOCK_SEL,
  output reg DEBUG_MODE,
  output reg BOUNDARY_SCAN_MODE,
  output reg TAP_RESET,
  output reg TEST_MODE_SELECT,
  output reg TEST_DATA,
  output reg [NUM_MODULES-1:0] MODULE_RESET,
  output reg [2:0] RESET_CAUSE
);
  localparam integer STABLE_CYC_RAW = (STABLE_NS + `RDM_CLK_NS - 1) / `RDM_CLK_NS;
  localparam integer STABLE_CYC = (STABLE_CYC_RAW < 1) ? 1 : STABLE_CYC_RAW;
  localparam ST_HOLD = 1'b0;
  localparam ST_RUN = 1'b1;

  // Undriven pins read as the internal pull-up level.
  wire ext_rst_n_pin = EXT_RESET_N_DRIVEN ? EXT_RESET_N_IN : 1'b1;
  wire sel_pin = TEST_PORT_SELECT_DRIVEN ? TEST_PORT_SELECT_IN : 1'b1;
  wire trst_n_pin = TEST_RESET_N_DRIVEN ? TEST_RESET_N_IN : 1'b1;
  wire tms_pin = TEST_MODE_SELECT_DRIVEN ? TEST_MODE_SELECT_IN : 1'b1;
  wire tdi_pin = TEST_DATA_DRIVEN ? TEST_DATA_IN : 1'b1;

  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 6'h3E;
      sync2_q <= 6'h3E;
    end else begin
      sync1_q <= {tdi_pin, tms_pin, trst_n_pin, sel_pin, ext_rst_n_pin,
                  OSC_STABLE};
      sync2_q <= sync1_q;
    end
  end
  wire osc_ok = sync2_q[0];
  wire ext_rst = ~sync2_q[1];
  wire sel_s = sync2_q[2];
  wire trst_n_s = sync2_q[3];
  wire tms_s = sync2_q[4];
  wire tdi_s = sync2_q[5];

  reg por1_q;
  reg por2_q;
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      por1_q <= 1'b1;
      por2_q <= 1'b1;
    end else begin
      por1_q <= POWER_UP_RESET;
      por2_q <= por1_q;
    end
  end

  // Hold and release of the internal reset. The count is in clock cycles, so
  // the hold time is only as exact as the clock period; it always rounds up.
  reg ext_rst_prev_q;
  reg state_q;
  reg state_d;
  reg [31:0] cnt_q;
  reg [31:0] cnt_d;
  reg int_rst_d;
  wire any_rst = ext_rst | por2_q;
  wire cnt_done = (cnt_q >= STABLE_CYC - 1);

  // Oscillator must stay stable for the whole count; a glitch restarts it.
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    int_rst_d = INTERNAL_RESET;
    case (state_q)
      ST_HOLD: begin
        int_rst_d = 1'b1;
        if (any_rst || !osc_ok) begin
          cnt_d = 32'h0;
        end else if (cnt_done) begin
          state_d = ST_RUN;
          int_rst_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      ST_RUN: begin
        if (any_rst || !osc_ok) begin
          state_d = ST_HOLD;
          int_rst_d = 1'b1;
          cnt_d = 32'h0;
        end
      end
      default: begin
        state_d = ST_HOLD;
        int_rst_d = 1'b1;
        cnt_d = 32'h0;
      end
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_HOLD;
      cnt_q <= 32'h0;
      INTERNAL_RESET <= 1'b1;
      ext_rst_prev_q <= 1'b0;
    end else begin
      ext_rst_prev_q <= ext_rst;
      state_q <= state_d;
      cnt_q <= cnt_d;
      INTERNAL_RESET <= int_rst_d;
    end
  end

  // Select is caught only on the rising edge of external reset, so a probe
  // pulling the pin later cannot swap the system clock under running code.
  // The previous-level flop resets to idle, so no false edge follows reset.
  wire ext_rst_rise = ext_rst & ~ext_rst_prev_q;
  reg clk_sel_d;
  reg debug_d;
  always @* begin
    clk_sel_d = SYSTEM_BASE_CLOCK_SEL;
    debug_d = DEBUG_MODE;
    if (ext_rst_rise) begin
      clk_sel_d = sel_s ? `RDM_CLK_SEL_LPOSC : `RDM_CLK_SEL_XTAL;
      debug_d = ~sel_s;
    end
  end

  // The two mode outputs come from one decision, so they can never agree.
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SYSTEM_BASE_CLOCK_SEL <= `RDM_CLK_SEL_LPOSC;
      DEBUG_MODE <= 1'b0;
      BOUNDARY_SCAN_MODE <= 1'b1;
    end else begin
      SYSTEM_BASE_CLOCK_SEL <= clk_sel_d;
      DEBUG_MODE <= debug_d;
      BOUNDARY_SCAN_MODE <= ~debug_d;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      TAP_RESET <= 1'b1;
      TEST_MODE_SELECT <= 1'b1;
      TEST_DATA <= 1'b1;
    end else begin
      TAP_RESET <= ~trst_n_s;
      TEST_MODE_SELECT <= tms_s;
      TEST_DATA <= tdi_s;
    end
  end

  wire any_mod = |MODULE_RESET_REQ;
  genvar i;
  generate
    for (i = 0; i < NUM_MODULES; i = i + 1) begin : g_mod
      always @(posedge MCLK or posedge RST) begin
        if (RST)
          MODULE_RESET[i] <= 1'b1;
        else
          MODULE_RESET[i] <= INTERNAL_RESET | MODULE_RESET_REQ[i];
      end
    end
  endgenerate

  // Cause bits are sticky; a new cause in the clear cycle wins, so a reset
  // that lands while software clears the record is never lost.
  reg [2:0] cause_d;
  always @* begin
    cause_d = RESET_CAUSE;
    if (CAUSE_CLEAR)
      cause_d = 3'h0;
    cause_d = cause_d | {any_mod, ext_rst, por2_q};
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST)
      RESET_CAUSE <= 3'h1;
    else
      RESET_CAUSE <= cause_d;
  end
endmodule // rdm_reset_debug_mode_select
`default_nettype wire

// file: verification/rdm_checker.sv
// Port assertions for the reset and debug-mode selector.
`timescale 1ns/1ps
`default_nettype none
module rdm_chk #(parameter NUM_MODULES = 8) (
  input wire logic MCLK, RST, EXT_RESET_N_IN, EXT_RESET_N_DRIVEN, OSC_STABLE,
  input wire logic TEST_RESET_N_IN, TEST_RESET_N_DRIVEN, INTERNAL_RESET,
  input wire logic SYSTEM_BASE_CLOCK_SEL, DEBUG_MODE, BOUNDARY_SCAN_MODE,
  input wire logic TAP_RESET,
  input wire logic [NUM_MODULES-1:0] MODULE_RESET_REQ, MODULE_RESET);
  wire xl = EXT_RESET_N_DRIVEN & ~EXT_RESET_N_IN;
  wire tl = TEST_RESET_N_DRIVEN & ~TEST_RESET_N_IN;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_x; xl[*4]; endsequence
  property p_md; DEBUG_MODE ^ BOUNDARY_SCAN_MODE; endproperty
  a_md: assert property (p_md) else $error("mode");
  property p_ck; DEBUG_MODE == SYSTEM_BASE_CLOCK_SEL; endproperty
  a_ck: assert property (p_ck) else $error("clock");
  property p_ex; s_x |=> INTERNAL_RESET; endproperty
  a_ex: assert property (p_ex) else $error("ext");
  property p_os; (!OSC_STABLE)[*4] |=> INTERNAL_RESET; endproperty
  a_os: assert property (p_os) else $error("osc");
  property p_rl; $fell(INTERNAL_RESET) |-> $past(OSC_STABLE, 3); endproperty
  a_rl: assert property (p_rl) else $error("release");
  property p_tp; tl[*4] |=> TAP_RESET; endproperty
  a_tp: assert property (p_tp) else $error("tap");
  property p_mr; |MODULE_RESET_REQ |=>
    &(MODULE_RESET | ~$past(MODULE_RESET_REQ)); endproperty
  a_mr: assert property (p_mr) else $error("module");
  property p_hd; (!xl)[*6] |-> $stable(SYSTEM_BASE_CLOCK_SEL); endproperty
  a_hd: assert property (p_hd) else $error("hold");
endmodule // rdm_chk
bind rdm_reset_debug_mode_select rdm_chk #(.NUM_MODULES(NUM_MODULES)) u_chk (.*);
`default_nettype wire

// file: verification/rdm_probe.sv
// Reset source and debug probe model for the external pins.
`timescale 1ns/1ps
`default_nettype none
module rdm_probe (input wire logic clk, input wire logic hold,
  input wire logic [1:0] cmd, output logic rn = 1'b1, rd = 1'b0, sl = 1'b1,
  sd = 1'b0);
  // A released pin toggles each cycle, so only its drive flag is trusted.
  always @(posedge clk) begin
    {rd, rn} <= {hold, hold ? 1'b0 : ~rn};
    {sd, sl} <= {cmd[1], cmd[1] ? cmd[0] : ~sl};
  end
endmodule // rdm_probe
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the reset and debug-mode selector.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic MCLK = 0, RST = 1, OSC_STABLE = 0, CAUSE_CLEAR = 0, rq = 0;
  logic POWER_UP_RESET = 0, TEST_DATA_IN = 0, TEST_DATA_DRIVEN = 0;
  logic TEST_RESET_N_IN = 1, TEST_RESET_N_DRIVEN = 0;
  logic TEST_MODE_SELECT_IN = 0, TEST_MODE_SELECT_DRIVEN = 0, TEST_DATA;
  logic EXT_RESET_N_IN, EXT_RESET_N_DRIVEN, TEST_PORT_SELECT_IN;
  logic TEST_PORT_SELECT_DRIVEN, INTERNAL_RESET, SYSTEM_BASE_CLOCK_SEL;
  logic DEBUG_MODE, BOUNDARY_SCAN_MODE, TAP_RESET, TEST_MODE_SELECT;
  logic [1:0] sc = 0;
  logic [2:0] RESET_CAUSE;
  logic [7:0] MODULE_RESET_REQ = 0, MODULE_RESET, v;
  int fail_count = 0, checks = 0, cyc = 0, k;
  always #2.5 MCLK = ~MCLK;
  rdm_probe u_prb (.clk(MCLK), .hold(rq), .cmd(sc), .rn(EXT_RESET_N_IN),
    .rd(EXT_RESET_N_DRIVEN), .sl(TEST_PORT_SELECT_IN),
    .sd(TEST_PORT_SELECT_DRIVEN));
  rdm_reset_debug_mode_select #(.STABLE_NS(20)) u_dut (.*);
  task ck(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t got %h", $time, g);
    end
  endtask
  task w(input int n); repeat (n) @(posedge MCLK); endtask
  // Bounded wait: a release that never comes is caught by the next compare, except in the select loop, whose next compare reads only the mode outputs.
  task rel; repeat (60) if (INTERNAL_RESET !== 1'b0) w(1); endtask
  task final_report;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge MCLK) if (++cyc > 999) begin fail_count++; final_report; end
  initial begin
    v = $urandom(93395);
    w(3); RST <= 0; w(20);
    ck({INTERNAL_RESET, RESET_CAUSE}, 8'h9);
    ck({TEST_MODE_SELECT, TEST_DATA}, 8'h3);
    OSC_STABLE <= 1;
    rel; ck(INTERNAL_RESET, 0);
    for (k = 0; k < 3; k++) begin
      sc <= 2'(2 + k);
      w(4); rq <= 1; w(8); rq <= 0; rel;
      ck({SYSTEM_BASE_CLOCK_SEL, DEBUG_MODE, BOUNDARY_SCAN_MODE},
        k ? 8'h1 : 8'h6);
      sc <= k ? 2'h2 : 2'h3; w(8);
      ck({DEBUG_MODE, RESET_CAUSE[1]}, {k == 0, 1'b1});
    end
    {TEST_RESET_N_DRIVEN, TEST_RESET_N_IN} <= 2'h2; w(5); ck(TAP_RESET, 1);
    TEST_RESET_N_DRIVEN <= 0; w(5); ck(TAP_RESET, 0);
    {TEST_MODE_SELECT_DRIVEN, TEST_DATA_DRIVEN} <= 2'h3; w(5);
    ck({TEST_MODE_SELECT, TEST_DATA}, 8'h0);
    {TEST_MODE_SELECT_DRIVEN, TEST_DATA_DRIVEN} <= 2'h0; w(5);
    ck({TEST_MODE_SELECT, TEST_DATA}, 8'h3);
    POWER_UP_RESET <= 1; w(6); ck({INTERNAL_RESET, RESET_CAUSE[0]}, 8'h3);
    POWER_UP_RESET <= 0; rel; ck(INTERNAL_RESET, 0);
    OSC_STABLE <= 0; w(8); ck(INTERNAL_RESET, 1);
    OSC_STABLE <= 1; rel; ck(INTERNAL_RESET, 0);
    CAUSE_CLEAR <= 1; w(2); CAUSE_CLEAR <= 0; v = $urandom_range(255, 1);
    MODULE_RESET_REQ <= v; w(3); ck(MODULE_RESET, v);
    ck(RESET_CAUSE, 8'h4);
    final_report;
  end
endmodule // tb
`default_nettype wire
